// [hdl/rom_block_a_decode.sv]
// Boot ROM block A: base/size register, address decode and write qualification
//
// Summary of operation
// - Compare 12-bit base against processor address bits 20-31 for block hits.
// - Larger sizes ignore low base bits; block starts at multiple of size.
// - Base field loads FF0 hex on power-up and local bus reset.
// - A vector set, B clear: first Mbyte of A also at FFF00000.
// - Vector bits pick top window source: none, A, or B overriding A.
// - Power-up reset loads A vector bit from its strap, not inverted.
// - Width bit clear means 8-bit block, set means 32-bit block.
// - Width bit captures its strap at power-up; software cannot change it.
// - Size codes 000..110 decode 1 to 64 Mbytes; 111 reserved.
// - Programmed range answers only while the enable bit is set.
// - Narrow takes byte writes, wide aligned word writes; others unanswered.
// - Permitted write with write-enable clear ends normally, no ROM write.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rom_block_a_params.svh"

module rom_block_a_decode
    import rom_block_a_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic localRst,
    input wire logic vector_strap_input,
    input wire logic width_strap_input,
    input wire logic block_b_vector_select,
    // AXI4-Lite register slave
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Processor bus request
    input wire logic procValid,
    input wire logic procWrite,
    input wire logic [31:0] procAddr,
    input wire logic [5:0] procSize,
    // Decode answer, one cycle after the request
    output logic accessAck,
    output logic romReadStrobe,
    output logic romWriteStrobe,
    output logic vectorWindowHit,
    output logic [25:0] romOffset,
    output logic blockWide
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------

    // Base compare mask: one more low bit ignored per size step
    function automatic base_field_t baseMask(input size_code_t siz);
        baseMask = `BLKA_BASE_FULL_MASK << siz;
    endfunction

    // Offset mask inside the block: 1 Mbyte shifted up by the size code
    function automatic block_offset_t offsetMask(input size_code_t siz);
        block_offset_t m;
        m = `BLKA_OFFSET_MIN_MASK;
        for (int i = 0; i < `BLKA_SIZE_CODES; i++) begin
            if (i < int'(siz)) begin
                m[`BLKA_MIN_SIZE_BITS + i] = 1'b1;
            end
        end
        offsetMask = m;
    endfunction

    // ------------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------------

    logic vectorStrapValue;
    logic vectorStrapLoad;
    logic widthStrapValue;
    logic widthStrapLoad;

    strap_capture vectorStrap (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .strapPin(vector_strap_input),
        .strapValue(vectorStrapValue),
        .strapLoad(vectorStrapLoad),
        .strapDone()
    );

    strap_capture widthStrap (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .strapPin(width_strap_input),
        .strapValue(widthStrapValue),
        .strapLoad(widthStrapLoad),
        .strapDone()
    );

    // ------------------------------------------------------------------------
    // Register fields
    // ------------------------------------------------------------------------

    base_field_t blockBase;
    size_code_t blockSize;
    logic blockWidth;
    logic vectorSelect;
    logic blockEnable;
    logic writeEnable;
    logic regWrite;
    logic [31:0] writeWord;
    logic [31:0] regImage;

    // Register image as software sees it; unused bits read zero
    always_comb begin
        regImage = 32'h0000_0000;
        regImage[`BLKA_BASE_MSB:`BLKA_BASE_LSB] = blockBase;
        regImage[`BLKA_WIDE_BIT] = blockWidth;
        regImage[`BLKA_SIZE_MSB:`BLKA_SIZE_LSB] = blockSize;
        regImage[`BLKA_VEC_BIT] = vectorSelect;
        regImage[`BLKA_EN_BIT] = blockEnable;
        regImage[`BLKA_WE_BIT] = writeEnable;
    end

    // Base: both resets restore the boot location
    always_ff @(posedge sys_clk) begin
        if (sys_rst || localRst) begin
            blockBase <= `BLKA_BASE_RESET;
        end else if (regWrite) begin
            blockBase <= writeWord[`BLKA_BASE_MSB:`BLKA_BASE_LSB];
        end
    end

    // Size, enable and write enable
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            blockSize <= `BLKA_SIZE_RESET;
            blockEnable <= `BLKA_EN_RESET;
            writeEnable <= `BLKA_WE_RESET;
        end else if (regWrite) begin
            blockSize <= writeWord[`BLKA_SIZE_MSB:`BLKA_SIZE_LSB];
            blockEnable <= writeWord[`BLKA_EN_BIT];
            writeEnable <= writeWord[`BLKA_WE_BIT];
        end
    end

    // Vector bit: strap at power-up, then software may change it
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            vectorSelect <= 1'b0;
        end else if (vectorStrapLoad) begin
            vectorSelect <= vectorStrapValue;
        end else if (regWrite) begin
            vectorSelect <= writeWord[`BLKA_VEC_BIT];
        end
    end

    // Width bit: taken from the strap only, writes never reach it
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            blockWidth <= 1'b0;
        end else if (widthStrapLoad) begin
            blockWidth <= widthStrapValue;
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------------

    logic awHeld;
    logic wHeld;
    logic [31:0] awAddrHeld;
    logic [31:0] wDataHeld;
    logic [3:0] wStrbHeld;
    logic writeHit;

    assign writeHit = (awAddrHeld[31:`BLKA_WORD_LSB] == `BLKA_REG_ADDR >> `BLKA_WORD_LSB);
    assign regWrite = awHeld && wHeld && !s_axi_bvalid && writeHit;

    // Merge the byte lanes into the current image
    always_comb begin
        writeWord = regImage;
        for (int b = 0; b < 4; b++) begin
            if (wStrbHeld[b]) begin
                writeWord[b * 8 +: 8] = wDataHeld[b * 8 +: 8];
            end
        end
    end

    // Address and data are taken independently, in either order
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            awHeld <= 1'b0;
            awAddrHeld <= 32'h0000_0000;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddrHeld <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (awHeld && wHeld && !s_axi_bvalid) begin
            awHeld <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wHeld <= 1'b0;
            wDataHeld <= 32'h0000_0000;
            wStrbHeld <= 4'h0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wDataHeld <= s_axi_wdata;
            wStrbHeld <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (awHeld && wHeld && !s_axi_bvalid) begin
            wHeld <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    // Response once both halves are in; unmapped addresses get SLVERR
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AXI_RESP_OKAY;
        end else if (awHeld && wHeld && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= writeHit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------------

    // One read at a time; the data word is registered at acceptance
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `AXI_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            if (s_axi_araddr[31:`BLKA_WORD_LSB] == `BLKA_REG_ADDR >> `BLKA_WORD_LSB) begin
                s_axi_rdata <= regImage;
                s_axi_rresp <= `AXI_RESP_OKAY;
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `AXI_RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------

    vector_source_e vectorSource;
    logic inWindow;
    logic rangeHit;
    logic blockHit;
    logic writeAllowed;
    block_offset_t next_romOffset;

    // Window source; B wins whenever its bit is set
    always_comb begin
        case ({vectorSelect, block_b_vector_select})
            2'b10: vectorSource = VEC_A;
            2'b01: vectorSource = VEC_B;
            2'b11: vectorSource = VEC_B;
            default: vectorSource = VEC_NONE;
        endcase
    end

    assign inWindow = (procAddr[`BLKA_ADDR_MSB:`BLKA_ADDR_LSB] == `BLKA_VECTOR_WINDOW);

    // Base match over upper address bits, low bits masked by size
    assign rangeHit = blockEnable && (blockSize != `BLKA_SIZE_RESERVED)
        && (((procAddr[`BLKA_ADDR_MSB:`BLKA_ADDR_LSB] ^ blockBase) & baseMask(blockSize)) == 12'h000);

    // The window belongs to B when B is the source, so A stays out of it
    always_comb begin
        case (vectorSource)
            VEC_A: blockHit = inWindow || rangeHit;
            VEC_B: blockHit = !inWindow && rangeHit;
            VEC_NONE: blockHit = rangeHit;
            default: blockHit = 1'b0;
        endcase
    end

    // Narrow block takes bytes, wide block takes aligned words
    always_comb begin
        if (blockWidth) begin
            writeAllowed = (procSize == `BLKA_XFER_WORD) && (procAddr[1:0] == `BLKA_ALIGN_ZERO);
        end else begin
            writeAllowed = (procSize == `BLKA_XFER_BYTE);
        end
    end

    // Offset into the block; window accesses with A as source land in its first Mbyte
    always_comb begin
        if (inWindow && (vectorSource == VEC_A)) begin
            next_romOffset = procAddr[`BLKA_OFFSET_MSB:0] & `BLKA_OFFSET_MIN_MASK;
        end else begin
            next_romOffset = procAddr[`BLKA_OFFSET_MSB:0] & offsetMask(blockSize);
        end
    end

    // ------------------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------------------

    // Registered answer; a refused write simply never sees an acknowledge
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            accessAck <= 1'b0;
            romReadStrobe <= 1'b0;
            romWriteStrobe <= 1'b0;
        end else begin
            accessAck <= 1'b0;
            romReadStrobe <= 1'b0;
            romWriteStrobe <= 1'b0;
            if (procValid && blockHit) begin
                if (!procWrite) begin
                    accessAck <= 1'b1;
                    romReadStrobe <= 1'b1;
                end else if (writeAllowed) begin
                    accessAck <= 1'b1;
                    romWriteStrobe <= writeEnable;
                end
            end
        end
    end

    // Offset and window flag follow each request for the device side
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            romOffset <= 26'h0000000;
            vectorWindowHit <= 1'b0;
        end else if (procValid) begin
            romOffset <= next_romOffset;
            vectorWindowHit <= blockHit && inWindow;
        end
    end

    // Width seen by the ROM data path
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            blockWide <= 1'b0;
        end else begin
            blockWide <= blockWidth;
        end
    end

endmodule

`default_nettype wire

// [hdl/rom_block_a_params.svh]
// Constants for the boot ROM block A decoder: offsets, fields, resets, codes
`ifndef ROM_BLOCK_A_PARAMS_SVH
`define ROM_BLOCK_A_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register address
// ----------------------------------------------------------------------------
`define BLKA_REG_ADDR 32'hFEF80050
`define BLKA_WORD_LSB 2

// ----------------------------------------------------------------------------
// Field positions inside the base/size word
// ----------------------------------------------------------------------------
`define BLKA_BASE_MSB 31
`define BLKA_BASE_LSB 20
`define BLKA_WIDE_BIT 19
`define BLKA_SIZE_MSB 18
`define BLKA_SIZE_LSB 16
`define BLKA_VEC_BIT 2
`define BLKA_EN_BIT 1
`define BLKA_WE_BIT 0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define BLKA_BASE_RESET 12'hFF0
`define BLKA_SIZE_RESET 3'h0
`define BLKA_EN_RESET 1'b1
`define BLKA_WE_RESET 1'b0

// ----------------------------------------------------------------------------
// Decode constants
// ----------------------------------------------------------------------------
`define BLKA_ADDR_MSB 31
`define BLKA_ADDR_LSB 20
`define BLKA_VECTOR_WINDOW 12'hFFF
`define BLKA_BASE_FULL_MASK 12'hFFF
`define BLKA_SIZE_RESERVED 3'h7
`define BLKA_OFFSET_MIN_MASK 26'h00FFFFF
`define BLKA_OFFSET_MSB 25
`define BLKA_MIN_SIZE_BITS 20
`define BLKA_SIZE_CODES 6
`define BLKA_XFER_BYTE 6'h01
`define BLKA_XFER_WORD 6'h04
`define BLKA_ALIGN_ZERO 2'h0

// ----------------------------------------------------------------------------
// AXI4-Lite response codes
// ----------------------------------------------------------------------------
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// [hdl/rom_block_a_pkg.sv]
// Types shared by the boot ROM block A decoder files
package rom_block_a_pkg;

    // Source of the top 1 Mbyte window, one-hot
    typedef enum logic [2:0] {
        VEC_NONE = 3'b001,
        VEC_A = 3'b010,
        VEC_B = 3'b100
    } vector_source_e;

    typedef logic [2:0] size_code_t;
    typedef logic [11:0] base_field_t;
    typedef logic [25:0] block_offset_t;

endpackage

// [hdl/strap_capture.sv]
// Strap sampler: three-flop synchroniser, one capture after power-up reset
`timescale 1ns/1ps
`default_nettype none

module strap_capture
    import rom_block_a_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic strapPin,
    output logic strapValue,
    output logic strapLoad,
    output logic strapDone
);

    logic syncA;
    logic syncB;
    logic syncC;

    // Synchroniser chain; the first stage feeds only the second
    always_ff @(posedge sys_clk) begin
        syncA <= strapPin;
        syncB <= syncA;
        syncC <= syncB;
    end

    // Capture once, after release, when the last two stages agree
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            strapValue <= 1'b0;
            strapLoad <= 1'b0;
            strapDone <= 1'b0;
        end else begin
            strapLoad <= 1'b0;
            if (!strapDone && (syncB == syncC)) begin
                strapValue <= syncC;
                strapLoad <= 1'b1;
                strapDone <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// [verif/rom_block_a_decode_chk.sv]
// Port-level checker for the boot ROM block A decoder
`timescale 1ns/1ps
`default_nettype none

module rom_block_a_decode_chk (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic block_b_vector_select,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic procValid,
    input wire logic procWrite,
    input wire logic [31:0] procAddr,
    input wire logic [5:0] procSize,
    input wire logic accessAck,
    input wire logic romReadStrobe,
    input wire logic romWriteStrobe,
    input wire logic vectorWindowHit,
    input wire logic [25:0] romOffset,
    input wire logic blockWide
);
    // Power-up reset masks everything; local reset leaves the bus running
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    // --------------------------------------------------------------
    // Processor side
    // --------------------------------------------------------------
    a_ack_has_cause: assert property (accessAck |-> $past(procValid))
        else $error("termination without a request");
    a_read_strobe: assert property (romReadStrobe |-> accessAck && !$past(procWrite))
        else $error("read strobe without a read termination");
    a_write_strobe: assert property (romWriteStrobe |-> accessAck && $past(procWrite))
        else $error("write strobe without a write termination");
    a_narrow_write: assert property ($past(procValid && procWrite && !blockWide && procSize != 6'h01)
        |-> !accessAck)
        else $error("narrow block answered a non-byte write");
    a_wide_write: assert property ($past(procValid && procWrite && blockWide
        && (procSize != 6'h04 || procAddr[1:0] != 2'h0)) |-> !accessAck)
        else $error("wide block answered a bad write");
    a_window_b_owns: assert property (procValid && procAddr[31:20] == 12'hFFF && block_b_vector_select
        |=> !accessAck)
        else $error("block A answered the top window while B owns it");
    a_window_offset: assert property (procValid && procAddr[31:20] == 12'hFFF
        |=> !vectorWindowHit || romOffset[19:0] == $past(procAddr[19:0]))
        else $error("top window offset wrong");
    // The copied width lags the field by one edge, so look one edge after the commit
    a_width_fixed: assert property ($rose(s_axi_bvalid) |=> $stable(blockWide))
        else $error("width changed by a register write");

    // --------------------------------------------------------------
    // Register bus
    // --------------------------------------------------------------
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");

    c_rom_write: cover property (romWriteStrobe);
    c_window_hit: cover property (accessAck && vectorWindowHit);
    c_reg_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind rom_block_a_decode rom_block_a_decode_chk i_chk (.*);

`default_nettype wire

// [verif/proc_bus_master.sv]
// Processor bus master model issuing one-cycle decode requests
`timescale 1ns/1ps
`default_nettype none

module proc_bus_master (
    input wire logic sys_clk,
    output logic procValid,
    output logic procWrite,
    output logic [31:0] procAddr,
    output logic [5:0] procSize
);
    // Idle bus at time zero
    initial begin
        procValid = 1'h0;
        procWrite = 1'h0;
        procAddr = 32'h0;
        procSize = 6'h0;
    end

    // One-cycle request; qualifiers inverted once taken so stale values never pass as valid
    task automatic issue(input logic w, input logic [31:0] a, input logic [5:0] s);
        @(posedge sys_clk);
        procValid <= 1'h1;
        procWrite <= w;
        procAddr <= a;
        procSize <= s;
        @(posedge sys_clk);
        procValid <= 1'h0;
        procWrite <= ~w;
        procAddr <= ~a;
        procSize <= ~s;
    endtask
endmodule

`default_nettype wire

// [verif/rom_block_a_decode_bench.sv]
// Self-checking bench for the boot ROM block A decoder
`timescale 1ns/1ps
`default_nettype none
`include "rom_block_a_params.svh"

module rom_block_a_decode_bench;
    logic sys_clk, sys_rst, localRst, vector_strap_input, width_strap_input, block_b_vector_select;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, procAddr, lim;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic procValid, procWrite, accessAck, romReadStrobe, romWriteStrobe, vectorWindowHit, blockWide;
    logic [5:0] procSize;
    logic [25:0] romOffset;
    int bad_count = 0;
    int comparisons = 0;

    rom_block_a_decode i_dut (.*);
    proc_bus_master i_master (.*);

    // 200 MHz clock
    initial begin
        sys_clk = 1'h0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Power-up reset with given strap levels; straps need a few edges to settle
    task automatic powerUp(input logic v, input logic w);
        @(posedge sys_clk);
        sys_rst <= 1'h1;
        vector_strap_input <= v;
        width_strap_input <= w;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'h0;
        repeat (8) @(posedge sys_clk);
    endtask

    task automatic axiWr(input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        check({30'h0, s_axi_bresp}, {30'h0, `AXI_RESP_OKAY});
    endtask

    task automatic axiRd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        check(s_axi_rdata, exp);
        check({30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    // Request, then look at ack and both strobes in the answer cycle
    task automatic req(input logic w, input logic [31:0] a, input logic [5:0] s, input logic [2:0] exp);
        i_master.issue(w, a, s);
        #1;
        check({29'h0, accessAck, romReadStrobe, romWriteStrobe}, {29'h0, exp});
    endtask

    // Hang guard, far beyond the few hundred cycles the sequence needs
    initial begin
        #200000;
        bad_count++;
        final_report();
    end

    // --------------------------------------------------------------
    // Sequence
    // --------------------------------------------------------------
    initial begin
        sys_rst = 1'h1;
        localRst = 1'h0;
        vector_strap_input = 1'h1;
        width_strap_input = 1'h0;
        block_b_vector_select = 1'h0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        powerUp(1'h1, 1'h0);
        axiRd(`BLKA_REG_ADDR, 32'hFF000006, `AXI_RESP_OKAY);
        check({31'h0, blockWide}, 32'h0);
        req(1'h0, 32'hFF012345, 6'h03, 3'h6);
        check({6'h0, romOffset}, 32'h00012345);
        check({31'h0, vectorWindowHit}, 32'h0);
        req(1'h0, 32'hFFF00010, 6'h08, 3'h6);
        check({6'h0, romOffset}, 32'h00000010);
        check({31'h0, vectorWindowHit}, 32'h1);
        @(posedge sys_clk);
        block_b_vector_select <= 1'h1;
        req(1'h0, 32'hFFF00010, 6'h08, 3'h0);
        check({31'h0, vectorWindowHit}, 32'h0);
        @(posedge sys_clk);
        block_b_vector_select <= 1'h0;
        req(1'h1, 32'hFF000001, 6'h01, 3'h4);
        req(1'h1, 32'hFF000000, 6'h04, 3'h0);
        req(1'h1, 32'hFF000000, 6'h02, 3'h0);
        axiWr(`BLKA_REG_ADDR, 32'h123A0003);
        axiRd(`BLKA_REG_ADDR, 32'h12320003, `AXI_RESP_OKAY);
        req(1'h1, 32'h12000004, 6'h01, 3'h5);
        check({6'h0, romOffset}, 32'h00000004);
        req(1'h0, 32'h12400000, 6'h01, 3'h0);
        // Size codes 0 to 6: last byte inside hits, first byte past misses
        for (int k = 0; k < 7; k++) begin
            axiWr(`BLKA_REG_ADDR, {13'h0, 3'(k), 16'h0003});
            lim = 32'h1 << (20 + k);
            req(1'h0, lim - 32'h1, 6'h01, 3'h6);
            check({6'h0, romOffset}, lim - 32'h1);
            req(1'h0, lim, 6'h01, 3'h0);
        end
        axiWr(`BLKA_REG_ADDR, 32'h00070003);
        req(1'h0, 32'h00000000, 6'h01, 3'h0);
        axiWr(`BLKA_REG_ADDR, 32'h00000001);
        req(1'h0, 32'h00000000, 6'h01, 3'h0);
        axiRd(32'hFEF80054, 32'h0, `AXI_RESP_SLVERR);
        @(posedge sys_clk);
        localRst <= 1'h1;
        @(posedge sys_clk);
        localRst <= 1'h0;
        axiRd(`BLKA_REG_ADDR, 32'hFF000001, `AXI_RESP_OKAY);
        // Wide block from the straps
        powerUp(1'h0, 1'h1);
        axiRd(`BLKA_REG_ADDR, 32'hFF080002, `AXI_RESP_OKAY);
        check({31'h0, blockWide}, 32'h1);
        req(1'h1, 32'hFF000004, 6'h04, 3'h4);
        req(1'h1, 32'hFF000006, 6'h04, 3'h0);
        req(1'h1, 32'hFF000000, 6'h01, 3'h0);
        req(1'h0, 32'hFFF00000, 6'h04, 3'h0);
        final_report();
    end
endmodule

`default_nettype wire
